//--- hw/record_writer_defs.vh
// Constants for the pulse record memory writer
`ifndef RECORD_WRITER_DEFS_VH
`define RECORD_WRITER_DEFS_VH

`define WORD_W 18
`define ADDR_W 10
`define TAG_DATA 2'h0
`define TAG_EMPTY 2'h1
`define TAG_HEADER 2'h2
`define TAG_END 2'h3
`define TRIG_CODE 5'h12
`define TS_CODE 8'h98
`define FILLER_WORD 18'h10000
`define END_WORD 18'h30000
`define MAX_PULSES 3'h4
`define OPT_RAW 2'h0
`define OPT_INTEGRAL 2'h1
`define OPT_TIMING 2'h2
`define FIRST_PULSE_LOC 10'h006
`define EMPTY_END_LOC 10'h008

`endif

//--- hw/record_word_pack.v
// Packs one record word from a word kind and its fields
`timescale 1ns/1ps
`default_nettype none
`include "record_writer_defs.vh"

module record_word_pack (
    input wire [3:0] kind,
    input wire empty_window,
    input wire [26:0] trigger_number,
    input wire [47:0] time_stamp,
    input wire [1:0] pulse_index,
    input wire [9:0] crossing_sample_index,
    input wire [15:0] sample,
    input wire [18:0] pulse_sum,
    input wire [5:0] fine_time,
    input wire [11:0] pulse_minimum,
    input wire [11:0] pulse_peak_value,
    output reg [17:0] word
);
    wire [1:0] low_tag;

    assign low_tag = empty_window ? `TAG_EMPTY : `TAG_DATA;

    always @* begin
        case (kind)
            4'h0: word = {`TAG_DATA, `TRIG_CODE, trigger_number[26:16]};
            4'h1: word = {`TAG_DATA, trigger_number[15:0]};
            4'h2: word = {`TAG_DATA, `TS_CODE, time_stamp[47:40]};
            4'h3: word = {`TAG_DATA, time_stamp[39:24]};
            4'h4: word = {low_tag, 8'h00, time_stamp[23:16]};
            4'h5: word = {low_tag, time_stamp[15:0]};
            4'h6: word = {`TAG_HEADER, 4'h0, pulse_index,
                          crossing_sample_index};
            4'h7: word = {`TAG_DATA, sample};
            4'h8: word = {`TAG_DATA, pulse_sum[18:3]};
            4'h9: word = {`TAG_DATA, 13'h0000, pulse_sum[2:0]};
            4'hA: word = {`TAG_DATA, 2'h0, fine_time,
                          pulse_minimum[11:4]};
            4'hB: word = {`TAG_DATA, pulse_minimum[3:0],
                          pulse_peak_value};
            4'hC: word = `FILLER_WORD;
            4'hD: word = `END_WORD;
            default: word = 18'h00000;
        endcase
    end
endmodule

`default_nettype wire

//--- hw/pulse_record_memory_writer.v
// Writes one per-channel capture window record into processing memory
// What this block does
// - Words 0-1: trigger code and trigger number
// - Words 2-5: 48-bit time stamp with code
// - Empty window tags words 4-5 with 01
// - Pulse header: tag 10, index, crossing sample index
// - At most four pulses, indexed in order
// - End-of-window word 11 after last entry
// - Empty window: filler at 6,7, end at 8
// - Integral option: two sum words per pulse
// - Timing word one: fine time, minimum high
// - Timing word two: minimum low, peak value
// - Pulse recognised when sample exceeds threshold
`timescale 1ns/1ps
`default_nettype none
`include "record_writer_defs.vh"

module pulse_record_memory_writer (
    input wire clk,
    input wire reset,
    input wire window_start,
    input wire [1:0] option,
    input wire [26:0] trigger_number,
    input wire [47:0] time_stamp,
    input wire [15:0] trigger_threshold,
    input wire sample_valid,
    input wire [15:0] sample,
    input wire [9:0] crossing_sample_index,
    input wire pulse_done,
    input wire pulse_result_valid,
    input wire [18:0] pulse_sum,
    input wire [5:0] fine_time,
    input wire [11:0] pulse_minimum,
    input wire [11:0] pulse_peak_value,
    input wire window_end,
    output reg mem_write_r,
    output reg [9:0] mem_addr_r,
    output reg [17:0] mem_data_r,
    output reg busy_r,
    output reg record_done_r
);
    localparam ST_IDLE = 3'h0;
    localparam ST_HEAD = 3'h1;
    localparam ST_SCAN = 3'h2;
    localparam ST_RESULT = 3'h3;
    localparam ST_FILL = 3'h4;
    localparam ST_END = 3'h5;

    reg [2:0] state_r;
    reg [2:0] head_cnt_r;
    reg [2:0] pulse_cnt_r;
    reg in_pulse_r;
    reg result_phase_r;
    reg fill_phase_r;
    reg [9:0] addr_ptr_r;
    reg [3:0] kind;
    reg do_write;
    reg [26:0] trig_r;
    reg [47:0] ts_r;
    reg [18:0] sum_r;
    reg [5:0] fine_r;
    reg [11:0] min_r;
    reg [11:0] peak_r;
    wire [17:0] packed_word;
    wire over_threshold;
    wire room_for_pulse;

    assign over_threshold = sample > trigger_threshold;
    assign room_for_pulse = pulse_cnt_r < `MAX_PULSES;

    record_word_pack u_pack (
        .kind(kind),
        .empty_window(pulse_cnt_r == 3'h0),
        .trigger_number(trig_r),
        .time_stamp(ts_r),
        .pulse_index(pulse_cnt_r[1:0]),
        .crossing_sample_index(crossing_sample_index),
        .sample(sample),
        .pulse_sum(sum_r),
        .fine_time(fine_r),
        .pulse_minimum(min_r),
        .pulse_peak_value(peak_r),
        .word(packed_word)
    );

    // Choice of word for this cycle
    always @* begin
        kind = 4'hF;
        do_write = 1'b0;
        case (state_r)
            ST_HEAD: begin
                kind = {1'b0, head_cnt_r};
                do_write = 1'b1;
            end
            ST_SCAN: begin
                if (sample_valid) begin
                    if (!in_pulse_r && over_threshold && room_for_pulse) begin
                        kind = 4'h6;
                        do_write = 1'b1;
                    end else if (in_pulse_r && option == `OPT_RAW) begin
                        kind = 4'h7;
                        do_write = 1'b1;
                    end
                end
            end
            ST_RESULT: begin
                do_write = 1'b1;
                if (option == `OPT_INTEGRAL) begin
                    kind = result_phase_r ? 4'h9 : 4'h8;
                end else begin
                    kind = result_phase_r ? 4'hB : 4'hA;
                end
            end
            ST_FILL: begin
                kind = 4'hC;
                do_write = 1'b1;
            end
            ST_END: begin
                kind = 4'hD;
                do_write = 1'b1;
            end
            default: begin
                kind = 4'hF;
                do_write = 1'b0;
            end
        endcase
    end

    // Header words 4 and 5 are written after the scan so the empty
    // tag is known; they still go to their fixed locations.
    always @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            head_cnt_r <= 3'h0;
            pulse_cnt_r <= 3'h0;
            in_pulse_r <= 1'b0;
            result_phase_r <= 1'b0;
            fill_phase_r <= 1'b0;
            addr_ptr_r <= 10'h000;
            trig_r <= 27'h0000000;
            ts_r <= 48'h000000000000;
            sum_r <= 19'h00000;
            fine_r <= 6'h00;
            min_r <= 12'h000;
            peak_r <= 12'h000;
            mem_write_r <= 1'b0;
            mem_addr_r <= 10'h000;
            mem_data_r <= 18'h00000;
            busy_r <= 1'b0;
            record_done_r <= 1'b0;
        end else begin
            mem_write_r <= do_write;
            record_done_r <= 1'b0;
            if (do_write) begin
                mem_data_r <= packed_word;
                if (state_r == ST_HEAD) begin
                    mem_addr_r <= {7'h00, head_cnt_r};
                end else begin
                    mem_addr_r <= addr_ptr_r;
                    addr_ptr_r <= addr_ptr_r + 10'h001;
                end
            end
            case (state_r)
                ST_IDLE: begin
                    busy_r <= 1'b0;
                    if (window_start) begin
                        trig_r <= trigger_number;
                        ts_r <= time_stamp;
                        addr_ptr_r <= 10'h000;
                        head_cnt_r <= 3'h0;
                        pulse_cnt_r <= 3'h0;
                        in_pulse_r <= 1'b0;
                        busy_r <= 1'b1;
                        state_r <= ST_HEAD;
                    end
                end
                ST_HEAD: begin
                    head_cnt_r <= head_cnt_r + 3'h1;
                    if (head_cnt_r == 3'h3) begin
                        addr_ptr_r <= `FIRST_PULSE_LOC;
                        state_r <= ST_SCAN;
                    end else if (head_cnt_r == 3'h5) begin
                        addr_ptr_r <= fill_phase_r ? `EMPTY_END_LOC
                                                   : addr_ptr_r;
                        state_r <= ST_END;
                    end
                end
                ST_SCAN: begin
                    if (sample_valid && !in_pulse_r && over_threshold &&
                        room_for_pulse) begin
                        in_pulse_r <= 1'b1;
                    end
                    if (in_pulse_r && pulse_result_valid) begin
                        sum_r <= pulse_sum;
                        fine_r <= fine_time;
                        min_r <= pulse_minimum;
                        peak_r <= pulse_peak_value;
                    end
                    if (in_pulse_r && pulse_done) begin
                        in_pulse_r <= 1'b0;
                        pulse_cnt_r <= pulse_cnt_r + 3'h1;
                        result_phase_r <= 1'b0;
                        if (option != `OPT_RAW) begin
                            state_r <= ST_RESULT;
                        end
                    end else if (window_end) begin
                        in_pulse_r <= 1'b0;
                        fill_phase_r <= 1'b0;
                        // A pulse cut off by the window end still counts
                        if (in_pulse_r) begin
                            pulse_cnt_r <= pulse_cnt_r + 3'h1;
                        end
                        if (pulse_cnt_r == 3'h0 && !in_pulse_r) begin
                            state_r <= ST_FILL;
                        end else begin
                            head_cnt_r <= 3'h4;
                            state_r <= ST_HEAD;
                        end
                    end
                end
                ST_RESULT: begin
                    result_phase_r <= 1'b1;
                    if (result_phase_r) begin
                        state_r <= ST_SCAN;
                    end
                end
                ST_FILL: begin
                    fill_phase_r <= 1'b1;
                    if (fill_phase_r) begin
                        head_cnt_r <= 3'h4;
                        state_r <= ST_HEAD;
                    end
                end
                ST_END: begin
                    state_r <= ST_IDLE;
                    busy_r <= 1'b0;
                    record_done_r <= 1'b1;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

//--- sim/pulse_record_memory_writer_properties.sv
// Checker for the record writer outputs
`timescale 1ns/1ps
`default_nettype none
`include "record_writer_defs.vh"
module record_writer_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic window_start,
    input wire logic [26:0] trigger_number,
    input wire logic [47:0] time_stamp,
    input wire logic mem_write_r,
    input wire logic [9:0] mem_addr_r,
    input wire logic [17:0] mem_data_r,
    input wire logic busy_r,
    input wire logic record_done_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [2:0] hdr_r;
    wire hdr_w = mem_write_r && mem_data_r[17:16] == `TAG_HEADER;
    always @(posedge clk) begin
        if (reset || (window_start && !busy_r)) hdr_r <= 3'h0;
        else if (hdr_w) hdr_r <= hdr_r + 3'h1;
    end
    property p_start;
        window_start && !busy_r |-> ##[1:2] (mem_write_r && mem_addr_r == 0)
            ##1 (mem_write_r && mem_addr_r == 1);
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_word0;
        mem_write_r && mem_addr_r == 0 |->
            mem_data_r == {2'h0, `TRIG_CODE, trigger_number[26:16]};
    endproperty
    a_word0: assert property (p_word0) else $error("bad word 0");
    property p_word2;
        mem_write_r && mem_addr_r == 2 |->
            mem_data_r == {2'h0, `TS_CODE, time_stamp[47:40]};
    endproperty
    a_word2: assert property (p_word2) else $error("bad word 2");
    property p_word4;
        mem_write_r && mem_addr_r == 4 |-> mem_data_r[15:8] == 8'h00;
    endproperty
    a_word4: assert property (p_word4) else $error("bad word 4");
    property p_end;
        mem_write_r && mem_data_r == `END_WORD |-> record_done_r && !busy_r;
    endproperty
    a_end: assert property (p_end) else $error("no done with end");
    property p_done;
        record_done_r |-> mem_write_r && mem_data_r == `END_WORD;
    endproperty
    a_done: assert property (p_done) else $error("done w/o end");
    property p_hdr;
        hdr_w |-> mem_data_r[15:10] == {4'h0, hdr_r[1:0]} && hdr_r < 3'h4;
    endproperty
    a_hdr: assert property (p_hdr) else $error("bad header");
    property p_fill;
        mem_write_r && mem_addr_r == 6 && mem_data_r == `FILLER_WORD |=>
            (mem_write_r && mem_addr_r == 7 && mem_data_r == `FILLER_WORD)
            ##1 (mem_write_r && mem_addr_r == 4 && mem_data_r[17:16] == 1)
            ##1 (mem_write_r && mem_addr_r == 5 && mem_data_r[17:16] == 1)
            ##1 (mem_write_r && mem_addr_r == 8 && mem_data_r == `END_WORD);
    endproperty
    a_fill: assert property (p_fill) else $error("bad empty");
    c_empty: cover property (mem_write_r && mem_data_r == `FILLER_WORD);
    c_four: cover property (hdr_w && hdr_r == 3'h3);
    c_done: cover property (record_done_r);
endmodule
bind pulse_record_memory_writer record_writer_checker chk_u (
    .clk(clk), .reset(reset), .window_start(window_start),
    .trigger_number(trigger_number), .time_stamp(time_stamp),
    .mem_write_r(mem_write_r), .mem_addr_r(mem_addr_r),
    .mem_data_r(mem_data_r), .busy_r(busy_r), .record_done_r(record_done_r));
`default_nettype wire

//--- sim/proc_mem_model.sv
// Processing memory model written by the record writer
`timescale 1ns/1ps
`default_nettype none
module proc_mem_model (
    input wire logic clk,
    input wire logic we,
    input wire logic [9:0] addr,
    input wire logic [17:0] data
);
    logic [17:0] mem [0:1023];
    always @(posedge clk) begin
        if (we) mem[addr] <= data;
    end
    task wipe;
        for (int i = 0; i < 1024; i++) mem[i] = 18'h3FFFF;
    endtask
endmodule
`default_nettype wire

//--- sim/pulse_record_memory_writer_bench.sv
// Bench for the pulse record memory writer
`timescale 1ns/1ps
`default_nettype none
`include "record_writer_defs.vh"
module pulse_record_memory_writer_bench;
    logic clk, reset, window_start, sample_valid, pulse_done, window_end;
    logic pulse_result_valid, mem_write_r, busy_r, record_done_r;
    logic [1:0] option;
    logic [3:0] strb;
    logic [26:0] trigger_number;
    logic [47:0] time_stamp;
    logic [15:0] trigger_threshold, sample;
    logic [9:0] crossing_sample_index, mem_addr_r;
    logic [18:0] pulse_sum;
    logic [5:0] fine_time;
    logic [11:0] pulse_minimum, pulse_peak_value;
    logic [17:0] mem_data_r;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    assign {window_start, pulse_result_valid, pulse_done, window_end} = strb;
    pulse_record_memory_writer dut_u (.clk(clk), .reset(reset),
        .window_start(window_start), .option(option),
        .trigger_number(trigger_number), .time_stamp(time_stamp),
        .trigger_threshold(trigger_threshold), .sample_valid(sample_valid),
        .sample(sample), .crossing_sample_index(crossing_sample_index),
        .pulse_done(pulse_done), .pulse_result_valid(pulse_result_valid),
        .pulse_sum(pulse_sum), .fine_time(fine_time),
        .pulse_minimum(pulse_minimum), .pulse_peak_value(pulse_peak_value),
        .window_end(window_end), .mem_write_r(mem_write_r),
        .mem_addr_r(mem_addr_r), .mem_data_r(mem_data_r), .busy_r(busy_r),
        .record_done_r(record_done_r));
    proc_mem_model mem_u (.clk(clk), .we(mem_write_r), .addr(mem_addr_r),
        .data(mem_data_r));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task chk(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("checks=%0d errors=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task sig(input logic [3:0] k);
        @(posedge clk) strb <= k;
        @(posedge clk) strb <= 4'h0;
    endtask
    task smp(input logic [15:0] v, input logic [9:0] ix);
        @(posedge clk) sample_valid <= 1'b1;
        sample <= v;
        crossing_sample_index <= ix;
        @(posedge clk) sample_valid <= 1'b0;
    endtask
    task begin_rec(input logic [1:0] opt);
        mem_u.wipe();
        option <= opt;
        trigger_number <= 27'h2A5_1234 + opt;
        time_stamp <= 48'hC3A5_5A3C_F00F + opt;
        sig(4'h8);
        repeat (6) @(posedge clk);
    endtask
    task end_rec(input logic e);
        int n;
        sig(4'h1);
        n = 0;
        while (record_done_r !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({17'h0, record_done_r}, 18'h1);
        // The end word reaches the memory one edge after done rises
        @(posedge clk);
        #1;
        chk(mem_u.mem[0], {2'h0, `TRIG_CODE, trigger_number[26:16]});
        chk(mem_u.mem[1], {2'h0, trigger_number[15:0]});
        chk(mem_u.mem[2], {2'h0, `TS_CODE, time_stamp[47:40]});
        chk(mem_u.mem[3], {2'h0, time_stamp[39:24]});
        chk(mem_u.mem[4], {1'b0, e, 8'h00, time_stamp[23:16]});
        chk(mem_u.mem[5], {1'b0, e, time_stamp[15:0]});
    endtask
    task t_empty;
        for (int o = 0; o < 3; o++) begin
            begin_rec(o[1:0]);
            end_rec(1'b1);
            chk(mem_u.mem[6], `FILLER_WORD);
            chk(mem_u.mem[7], `FILLER_WORD);
            chk(mem_u.mem[8], `END_WORD);
        end
    endtask
    task t_raw;
        begin_rec(`OPT_RAW);
        smp(16'h0100, 10'h001);
        smp(16'h0101, 10'h002);
        smp(16'h0210, 10'h003);
        smp(16'h0050, 10'h004);
        sig(4'h2);
        repeat (2) @(posedge clk);
        end_rec(1'b0);
        chk(mem_u.mem[6], {`TAG_HEADER, 6'h00, 10'h002});
        chk(mem_u.mem[7], {2'h0, 16'h0210});
        chk(mem_u.mem[8], {2'h0, 16'h0050});
        chk(mem_u.mem[9], `END_WORD);
    endtask
    task t_int;
        logic [18:0] s;
        logic [17:0] h;
        begin_rec(`OPT_INTEGRAL);
        for (int p = 0; p < 5; p++) begin
            smp(16'h0400, 10'(p * 9));
            smp(16'h0500, 10'h3FF);
            pulse_sum <= 19'h45678 + 19'(p * 19'h01111);
            if (p < 4) sig(4'h6);
            repeat (3) @(posedge clk);
        end
        end_rec(1'b0);
        for (int p = 0; p < 4; p++) begin
            s = 19'h45678 + 19'(p * 19'h01111);
            h = {`TAG_HEADER, 4'h0, 2'(p), 10'(p * 9)};
            chk(mem_u.mem[6 + 3 * p], h);
            chk(mem_u.mem[7 + 3 * p], {2'h0, s[18:3]});
            chk(mem_u.mem[8 + 3 * p], {15'h0, s[2:0]});
        end
        chk(mem_u.mem[18], `END_WORD);
    endtask
    task t_tim;
        begin_rec(`OPT_TIMING);
        fine_time <= 6'h2A;
        pulse_minimum <= 12'hABC;
        pulse_peak_value <= 12'h5E7;
        smp(16'hFFFF, 10'h3FF);
        sig(4'h4);
        sig(4'h2);
        repeat (3) @(posedge clk);
        end_rec(1'b0);
        chk(mem_u.mem[6], {`TAG_HEADER, 6'h00, 10'h3FF});
        chk(mem_u.mem[7], {4'h0, 6'h2A, 8'hAB});
        chk(mem_u.mem[8], {2'h0, 4'hC, 12'h5E7});
        chk(mem_u.mem[9], `END_WORD);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        {strb, option, trigger_number, time_stamp, sample_valid, sample} = '0;
        {crossing_sample_index, pulse_sum, fine_time, pulse_minimum} = '0;
        pulse_peak_value = 12'h000;
        trigger_threshold = 16'h0100;
        reset = 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_empty();
        t_raw();
        t_int();
        t_tim();
        summarize();
    end
endmodule
`default_nettype wire
